// File: verilog/mni_pkg.sv
// shared constants and state enumerations of the nibble media interface
package mni_pkg;
    localparam int NIB_W = 4; // nibble width on both buses
    localparam int BYTE_W = 8; // user-side byte width
    localparam int CNT_W = 5; // width of the nibble counters
    localparam int EV_N = 3; // events per direction
    // nibble codes
    localparam logic [NIB_W-1:0] NIB_PREAMBLE = 4'h5;
    localparam logic [NIB_W-1:0] NIB_SFD = 4'hD;
    localparam logic [NIB_W-1:0] NIB_JAM = 4'h5;
    localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;
    localparam logic [NIB_W-1:0] RX_CODE_FALSE_CARRIER = 4'hE;
    localparam logic [NIB_W-1:0] RX_CODE_IDLE = 4'h0;
    // nibble counts
    localparam logic [CNT_W-1:0] PREAMBLE_NIBBLES = 5'h0F;
    localparam logic [CNT_W-1:0] JAM_NIBBLES = 5'h08;
    localparam logic [CNT_W-1:0] GAP_NIBBLES = 5'h18;
    // event bit positions, transmit side
    localparam int EV_TX_DONE = 0;
    localparam int EV_TX_COLL = 1;
    localparam int EV_TX_UNDER = 2;
    // event bit positions, receive side
    localparam int EV_RX_ERR = 0;
    localparam int EV_RX_FALSE = 1;
    localparam int EV_RX_RSVD = 2;
    // transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE, TX_PRE, TX_SFD, TX_LO, TX_HI, TX_JAM, TX_DRAIN, TX_GAP
    } mni_tx_state_t;
    // receive sequencer states
    typedef enum logic [1:0] {
        RX_HUNT, RX_LO, RX_HI
    } mni_rx_state_t;
endpackage : mni_pkg

// File: verilog/mni_sync.sv
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module mni_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import mni_pkg::*;

    // both stages of the chain
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mni_sync_st_t;

    mni_sync_st_t st_r;
    mni_sync_st_t st_nxt;

    // refuse a chain of no bits
    if (W < 1) begin : g_bad_width
        $error("mni_sync: width must be at least one");
    end

    // first stage feeds only the second
    always_comb begin
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    // registers of the chain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;
endmodule : mni_sync

// File: verilog/mni_evt_xfer.sv
// toggle crossing of one-cycle event pulses into another clock domain
`timescale 1ns/1ps
module mni_evt_xfer #(
    parameter int N = 1
) (
    input wire logic srcClk,
    input wire logic dstClk,
    input wire logic nrst,
    input wire logic [N-1:0] srcPulse,
    output logic [N-1:0] dstPulse
);
    import mni_pkg::*;

    // source side: one toggle per event bit
    typedef struct packed {
        logic [N-1:0] tog;
    } mni_xsrc_st_t;

    // destination side: sync chain, edge stage, output pulse
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] pulse;
    } mni_xdst_st_t;

    mni_xsrc_st_t src_r;
    mni_xsrc_st_t src_nxt;
    mni_xdst_st_t dst_r;
    mni_xdst_st_t dst_nxt;

    if (N < 1) begin : g_bad_n
        $error("mni_evt_xfer: need at least one event");
    end

    // flip the toggle once per event; two events within one destination
    // clock cancel and both are lost, acceptable for rare events
    always_comb begin
        src_nxt.tog = src_r.tog ^ srcPulse;
    end

    always_ff @(posedge srcClk or negedge nrst) begin
        if (!nrst) begin
            src_r <= '0;
        end else begin
            src_r <= src_nxt;
        end
    end

    // s1 is read only by s2; edges are found between s2 and s3
    always_comb begin
        dst_nxt.s1 = src_r.tog;
        dst_nxt.s2 = dst_r.s1;
        dst_nxt.s3 = dst_r.s2;
        dst_nxt.pulse = dst_r.s2 ^ dst_r.s3;
    end

    always_ff @(posedge dstClk or negedge nrst) begin
        if (!nrst) begin
            dst_r <= '0;
        end else begin
            dst_r <= dst_nxt;
        end
    end

    assign dstPulse = dst_r.pulse;
endmodule : mni_evt_xfer

// File: verilog/mni_media_if.sv
// nibble media interface of a 10/100 mac: transmit, receive, carrier and collision
//
// Behaviour
// - runs at 10 and 100 Mb/s, half and full duplex
// - contention handling only in half duplex
// - transmit enable starts with first preamble nibble
// - 4-bit transmit nibble, bit 0 least significant
// - carrier and collision synchronised, ignored in full duplex
// - accept shortened preamble, valid by delimiter
// - receive error with valid marks frame bad
// - idle error codes: false carrier, inter-frame, reserved
`timescale 1ns/1ps
module mni_media_if (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fullDuplex,
    input wire logic txClk,
    input wire logic [mni_pkg::BYTE_W-1:0] txData,
    input wire logic txValid,
    input wire logic txLast,
    output logic txReady,
    input wire logic rxClk,
    output logic [mni_pkg::BYTE_W-1:0] rxData,
    output logic rxValid,
    output logic rxFrameEnd,
    output logic rxFrameErr,
    output logic miiTxEn,
    output logic [mni_pkg::NIB_W-1:0] miiTxd,
    input wire logic miiRxDv,
    input wire logic miiRxEr,
    input wire logic [mni_pkg::NIB_W-1:0] miiRxd,
    input wire logic miiCrs,
    input wire logic miiCol,
    output logic crsSense,
    output logic colSense,
    output logic txDonePulse,
    output logic txCollisionPulse,
    output logic txUnderrunPulse,
    output logic rxErrorPulse,
    output logic falseCarrierPulse,
    output logic reservedCodePulse
);
    import mni_pkg::*;

    // transmit-side state, all on the phy transmit clock
    typedef struct packed {
        mni_tx_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [BYTE_W-1:0] dat;
        logic lastSeen;
        logic en;
        logic [NIB_W-1:0] txd;
        logic [EV_N-1:0] evt;
    } mni_tx_st_t;

    // receive-side state, all on the phy receive clock
    typedef struct packed {
        logic dv;
        logic er;
        logic [NIB_W-1:0] d;
        mni_rx_state_t st;
        logic [NIB_W-1:0] lo;
        logic err;
        logic [BYTE_W-1:0] data;
        logic valid;
        logic fend;
        logic ferr;
        logic [EV_N-1:0] evt;
    } mni_rx_st_t;

    mni_tx_st_t txS_r;
    mni_tx_st_t txS_nxt;
    mni_rx_st_t rxS_r;
    mni_rx_st_t rxS_nxt;

    logic [1:0] lineTx; // crs, col seen on transmit clock
    logic [1:0] lineCore; // crs, col seen on core clock
    logic fdTx; // duplex mode on transmit clock
    logic crsTx;
    logic colTx;
    logic collide; // live collision during a frame
    logic takeOk; // a byte is offered when one is wanted
    logic readyC; // byte wanted this cycle
    logic [EV_N-1:0] txEvtCore;
    logic [EV_N-1:0] rxEvtCore;

    // asynchronous phy line states, synchronised before use
    mni_sync #(.W(2)) u_sync_line_tx (
        .clk(txClk),
        .nrst(nrst),
        .din({miiCrs, miiCol}),
        .dout(lineTx)
    );

    mni_sync #(.W(2)) u_sync_line_core (
        .clk(core_clk),
        .nrst(nrst),
        .din({miiCrs, miiCol}),
        .dout(lineCore)
    );

    // duplex selection comes from the core domain
    mni_sync #(.W(1)) u_sync_fd (
        .clk(txClk),
        .nrst(nrst),
        .din(fullDuplex),
        .dout(fdTx)
    );

    // in full duplex the line states are don't care
    assign crsTx = lineTx[1] & ~fdTx;
    assign colTx = lineTx[0] & ~fdTx;

    // only frames on the wire can collide
    always_comb begin
        collide = colTx && (txS_r.st == TX_PRE || txS_r.st == TX_SFD ||
            txS_r.st == TX_LO || txS_r.st == TX_HI);
    end

    // transmit sequencer; the phy clock sets the rate, so one
    // sequencer serves both 2.5 and 25 MHz nibble clocks
    always_comb begin
        txS_nxt = txS_r;
        txS_nxt.evt = '0;
        readyC = 1'b0;
        takeOk = 1'b0;
        unique case (txS_r.st)
            TX_IDLE: begin
                txS_nxt.en = 1'b0;
                txS_nxt.txd = NIB_IDLE;
                txS_nxt.lastSeen = 1'b0;
                // half duplex defers while the medium is busy
                if (txValid && !crsTx) begin
                    txS_nxt.st = TX_PRE;
                    txS_nxt.cnt = '0;
                    txS_nxt.en = 1'b1;
                    txS_nxt.txd = NIB_PREAMBLE;
                end
            end
            TX_PRE: begin
                if (txS_r.cnt == PREAMBLE_NIBBLES - 5'h01) begin
                    txS_nxt.st = TX_SFD;
                    txS_nxt.txd = NIB_SFD;
                end else begin
                    txS_nxt.cnt = txS_r.cnt + 5'h01;
                    txS_nxt.txd = NIB_PREAMBLE;
                end
            end
            TX_SFD, TX_HI: begin
                if (txS_r.st == TX_HI && txS_r.lastSeen) begin
                    // frame complete, enable drops with the clock
                    txS_nxt.en = 1'b0;
                    txS_nxt.txd = NIB_IDLE;
                    txS_nxt.st = TX_GAP;
                    txS_nxt.cnt = '0;
                    txS_nxt.evt[EV_TX_DONE] = 1'b1;
                end else begin
                    readyC = 1'b1;
                    takeOk = txValid;
                end
            end
            TX_LO: begin
                txS_nxt.txd = txS_r.dat[7:4];
                txS_nxt.st = TX_HI;
            end
            TX_JAM: begin
                if (txS_r.cnt == JAM_NIBBLES - 5'h01) begin
                    txS_nxt.en = 1'b0;
                    txS_nxt.txd = NIB_IDLE;
                    txS_nxt.cnt = '0;
                    txS_nxt.st = txS_r.lastSeen ? TX_GAP : TX_DRAIN;
                end else begin
                    txS_nxt.cnt = txS_r.cnt + 5'h01;
                end
            end
            TX_DRAIN: begin
                // discard the rest of an aborted frame
                readyC = 1'b1;
                if (txValid && txLast) begin
                    txS_nxt.st = TX_GAP;
                    txS_nxt.cnt = '0;
                end
            end
            TX_GAP: begin
                // inter-frame gap, counted in nibbles
                if (txS_r.cnt == GAP_NIBBLES - 5'h01) begin
                    txS_nxt.st = TX_IDLE;
                end else begin
                    txS_nxt.cnt = txS_r.cnt + 5'h01;
                end
            end
        endcase
        // byte hand-off, low nibble goes out first; drain only swallows bytes
        if (readyC && txS_r.st != TX_DRAIN) begin
            if (takeOk) begin
                txS_nxt.dat = txData;
                txS_nxt.lastSeen = txLast;
                txS_nxt.txd = txData[3:0];
                txS_nxt.st = TX_LO;
            end else begin
                // underrun: the frame cannot continue, cut it short
                txS_nxt.en = 1'b0;
                txS_nxt.txd = NIB_IDLE;
                txS_nxt.st = TX_DRAIN;
                txS_nxt.evt[EV_TX_UNDER] = 1'b1;
            end
        end
        // collision wins over any data step
        if (collide) begin
            txS_nxt = txS_r;
            txS_nxt.evt = '0;
            txS_nxt.evt[EV_TX_COLL] = 1'b1;
            txS_nxt.st = TX_JAM;
            txS_nxt.cnt = '0;
            txS_nxt.en = 1'b1;
            txS_nxt.txd = NIB_JAM;
        end
    end

    // transmit registers run on the phy transmit clock
    always_ff @(posedge txClk or negedge nrst) begin
        if (!nrst) begin
            txS_r <= '{st: TX_IDLE, default: '0};
        end else begin
            txS_r <= txS_nxt;
        end
    end

    // no byte is taken in the cycle a collision hits
    assign txReady = readyC & ~collide;
    assign miiTxEn = txS_r.en;
    assign miiTxd = txS_r.txd;

    // receive sequencer; inputs share the receive clock so one
    // register stage aligns them, no synchroniser needed
    always_comb begin
        rxS_nxt = rxS_r;
        rxS_nxt.dv = miiRxDv;
        rxS_nxt.er = miiRxEr;
        rxS_nxt.d = miiRxd;
        rxS_nxt.valid = 1'b0;
        rxS_nxt.fend = 1'b0;
        rxS_nxt.evt = '0;
        unique case (rxS_r.st)
            RX_HUNT: begin
                if (rxS_r.dv) begin
                    // any preamble length, even none, before the delimiter
                    rxS_nxt.err = rxS_r.err | rxS_r.er;
                    if (rxS_r.d == NIB_SFD) begin
                        rxS_nxt.st = RX_LO;
                    end
                end else begin
                    rxS_nxt.err = 1'b0;
                    if (rxS_r.er) begin
                        if (rxS_r.d == RX_CODE_FALSE_CARRIER) begin
                            rxS_nxt.evt[EV_RX_FALSE] = 1'b1;
                        end else if (rxS_r.d != RX_CODE_IDLE) begin
                            rxS_nxt.evt[EV_RX_RSVD] = 1'b1;
                        end
                    end
                end
            end
            RX_LO: begin
                if (rxS_r.dv) begin
                    rxS_nxt.lo = rxS_r.d;
                    rxS_nxt.err = rxS_r.err | rxS_r.er;
                    rxS_nxt.st = RX_HI;
                end else begin
                    // frame ended on a byte boundary
                    rxS_nxt.fend = 1'b1;
                    rxS_nxt.ferr = rxS_r.err;
                    rxS_nxt.evt[EV_RX_ERR] = rxS_r.err;
                    rxS_nxt.err = 1'b0;
                    rxS_nxt.st = RX_HUNT;
                end
            end
            RX_HI: begin
                if (rxS_r.dv) begin
                    rxS_nxt.data = {rxS_r.d, rxS_r.lo};
                    rxS_nxt.valid = 1'b1;
                    rxS_nxt.err = rxS_r.err | rxS_r.er;
                    rxS_nxt.st = RX_LO;
                end else begin
                    // odd nibble left over: the frame is flagged bad
                    rxS_nxt.fend = 1'b1;
                    rxS_nxt.ferr = 1'b1;
                    rxS_nxt.evt[EV_RX_ERR] = 1'b1;
                    rxS_nxt.err = 1'b0;
                    rxS_nxt.st = RX_HUNT;
                end
            end
            // the fourth state code is unused; fall back to hunting
            default: rxS_nxt.st = RX_HUNT;
        endcase
    end

    // receive registers run on the phy receive clock
    always_ff @(posedge rxClk or negedge nrst) begin
        if (!nrst) begin
            rxS_r <= '{st: RX_HUNT, default: '0};
        end else begin
            rxS_r <= rxS_nxt;
        end
    end

    assign rxData = rxS_r.data;
    assign rxValid = rxS_r.valid;
    assign rxFrameEnd = rxS_r.fend;
    assign rxFrameErr = rxS_r.ferr;

    // transmit events into the core domain
    mni_evt_xfer #(.N(EV_N)) u_xfer_tx (
        .srcClk(txClk),
        .dstClk(core_clk),
        .nrst(nrst),
        .srcPulse(txS_r.evt),
        .dstPulse(txEvtCore)
    );

    // receive events into the core domain
    mni_evt_xfer #(.N(EV_N)) u_xfer_rx (
        .srcClk(rxClk),
        .dstClk(core_clk),
        .nrst(nrst),
        .srcPulse(rxS_r.evt),
        .dstPulse(rxEvtCore)
    );

    // core-side status; carrier and collision sense masked in full duplex, event pulses not
    assign crsSense = lineCore[1] & ~fullDuplex;
    assign colSense = lineCore[0] & ~fullDuplex;
    assign txDonePulse = txEvtCore[EV_TX_DONE];
    assign txCollisionPulse = txEvtCore[EV_TX_COLL];
    assign txUnderrunPulse = txEvtCore[EV_TX_UNDER];
    assign rxErrorPulse = rxEvtCore[EV_RX_ERR];
    assign falseCarrierPulse = rxEvtCore[EV_RX_FALSE];
    assign reservedCodePulse = rxEvtCore[EV_RX_RSVD];
endmodule : mni_media_if

// File: verif/mni_media_if_assertions.sv
// port-level checks of the nibble media interface
`timescale 1ns/1ps
module mni_media_if_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fullDuplex,
    input wire logic txClk,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic rxClk,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxFrameEnd,
    input wire logic rxFrameErr,
    input wire logic miiTxEn,
    input wire logic [3:0] miiTxd,
    input wire logic miiCrs,
    input wire logic miiCol,
    input wire logic crsSense,
    input wire logic colSense,
    input wire logic falseCarrierPulse,
    input wire logic reservedCodePulse
);
    // idle wire carries zero
    AST_TXD_IDLE: assert property (@(posedge txClk) disable iff (!nrst)
        !miiTxEn |-> miiTxd == 4'h0) else $error("txd not zero while idle");
    // fifteen preamble nibbles, then the delimiter; a jam would cut it short
    AST_TX_PRE: assert property (@(posedge txClk) disable iff (!nrst)
        $rose(miiTxEn) && fullDuplex |-> (miiTxd == 4'h5) [*8] ##1 (miiTxd == 4'h5) [*7]
        ##1 miiTxd == 4'hD) else $error("preamble wrong");
    AST_TX_START: assert property (@(posedge txClk) disable iff (!nrst)
        $rose(miiTxEn) |-> $past(txValid)) else $error("enable rose unasked");
    // taken byte leaves low nibble first
    AST_TX_ORDER: assert property (@(posedge txClk) disable iff (!nrst)
        txValid && txReady && fullDuplex |=> miiTxEn && miiTxd == 4'($past(txData))
        ##1 miiTxd == 4'($past(txData, 2) >> 4)) else $error("tx nibble order");
    AST_FD_MUTE: assert property (@(posedge core_clk) disable iff (!nrst)
        fullDuplex |-> !crsSense && !colSense) else $error("carrier in full duplex");
    // carrier follows the pin two core edges late
    AST_CRS_SYNC: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(crsSense) && $stable(fullDuplex) && !fullDuplex
        |-> crsSense == $past(miiCrs, 2)) else $error("carrier sense latency");
    // collision follows the pin two core edges late
    AST_COL_SYNC: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(colSense) && $stable(fullDuplex) && !fullDuplex
        |-> colSense == $past(miiCol, 2)) else $error("collision sense latency");
    AST_RX_STROBE: assert property (@(posedge rxClk) disable iff (!nrst)
        rxValid |=> !rxValid) else $error("rx strobe too long");
    AST_RX_DATA: assert property (@(posedge rxClk) disable iff (!nrst)
        $changed(rxData) |-> rxValid) else $error("rx data moved alone");
    AST_RX_STATUS: assert property (@(posedge rxClk) disable iff (!nrst)
        $changed(rxFrameErr) |-> rxFrameEnd) else $error("frame status moved alone");
    // one idle code gives one kind of event
    AST_RX_CODE: assert property (@(posedge core_clk) disable iff (!nrst)
        falseCarrierPulse |-> !reservedCodePulse ##1 !falseCarrierPulse)
        else $error("idle code events clash");
endmodule : mni_media_if_chk
bind mni_media_if mni_media_if_chk u_chk (.core_clk, .nrst, .fullDuplex, .txClk, .txData,
    .txValid, .txReady, .rxClk, .rxData, .rxValid, .rxFrameEnd, .rxFrameErr, .miiTxEn,
    .miiTxd, .miiCrs, .miiCol, .crsSense, .colSense, .falseCarrierPulse, .reservedCodePulse);

// File: verif/mni_phy_model.sv
// behavioural phy: link clocks, receive frames, transmit capture
`timescale 1ns/1ps
module mni_phy_model (
    output logic txClk,
    output logic rxClk,
    output logic miiRxDv,
    output logic miiRxEr,
    output logic [3:0] miiRxd,
    output logic miiCrs,
    output logic miiCol,
    input wire logic miiTxEn,
    input wire logic [3:0] miiTxd
);
    logic [3:0] txCap[$]; // nibbles sent under enable
    logic colOn; // bench asks for a collision
    logic rxAct; // receive medium busy
    // free-running clocks, phased away from the core edges
    initial begin
        {txClk, rxClk, miiRxDv, miiRxEr, colOn, rxAct} = 6'h00;
        miiRxd = 4'h0;
        fork
            begin #7; forever #80 txClk = ~txClk; end
            begin #33; forever #80 rxClk = ~rxClk; end
        join
    end
    assign miiCol = colOn & miiTxEn;
    assign miiCrs = miiTxEn | rxAct | miiCol;
    // data without enable is inter-frame, not kept
    always @(posedge txClk) if (miiTxEn) txCap.push_back(miiTxd);
    // one frame of nibbles, error flag on nibble errAt
    task automatic send_nibs(input logic [3:0] nib[$], input int errAt);
        @(posedge rxClk);
        rxAct <= 1'h1;
        for (int i = 0; i < nib.size(); i++) begin
            miiRxDv <= 1'h1;
            miiRxd <= nib[i];
            miiRxEr <= (i == errAt);
            @(posedge rxClk);
        end
        miiRxDv <= 1'h0;
        miiRxEr <= 1'h0;
        miiRxd <= ~miiRxd; // no stale nibble once released
        rxAct <= 1'h0;
    endtask : send_nibs
    // one idle cycle carrying an error code
    task automatic send_code(input logic [3:0] code);
        @(posedge rxClk);
        miiRxEr <= 1'h1;
        miiRxd <= code;
        @(posedge rxClk);
        miiRxEr <= 1'h0;
        miiRxd <= ~code;
    endtask : send_code
endmodule : mni_phy_model

// File: verif/mni_media_if_tb.sv
// self-checking bench of the nibble media interface
`timescale 1ns/1ps
module mni_media_if_tb;
    import mni_pkg::*;
    logic core_clk, nrst, fullDuplex, txClk, rxClk, txValid, txLast, txReady;
    logic rxValid, rxFrameEnd, rxFrameErr, miiTxEn, miiRxDv, miiRxEr, miiCrs, miiCol;
    logic crsSense, colSense, lastErr;
    logic [7:0] txData, rxData;
    logic [3:0] miiTxd, miiRxd;
    wire [5:0] evs; // done, collision, underrun, rx error, false carrier, reserved
    int evCnt[6]; // pulses seen per event
    int err_total, total_checks, seed, frames;
    logic [7:0] rxGot[$]; // bytes handed over
    logic [3:0] codes[4] = '{4'hE, 4'h0, 4'h3, 4'hF}; // idle error codes
    mni_media_if u_mni_media_if (.core_clk, .nrst, .fullDuplex, .txClk, .txData, .txValid,
        .txLast, .txReady, .rxClk, .rxData, .rxValid, .rxFrameEnd, .rxFrameErr, .miiTxEn,
        .miiTxd, .miiRxDv, .miiRxEr, .miiRxd, .miiCrs, .miiCol, .crsSense, .colSense,
        .txDonePulse(evs[0]), .txCollisionPulse(evs[1]), .txUnderrunPulse(evs[2]),
        .rxErrorPulse(evs[3]), .falseCarrierPulse(evs[4]), .reservedCodePulse(evs[5]));
    mni_phy_model u_mni_phy_model (.txClk, .rxClk, .miiRxDv, .miiRxEr, .miiRxd, .miiCrs,
        .miiCol, .miiTxEn, .miiTxd);
    initial core_clk = 1'h0;
    always #50 core_clk = ~core_clk;
    // count core event pulses
    always @(posedge core_clk) for (int k = 0; k < 6; k++) evCnt[k] += int'(evs[k]);
    // collect bytes and frame ends
    always @(posedge rxClk) begin
        if (rxValid === 1'h1) rxGot.push_back(rxData);
        if (rxFrameEnd === 1'h1) begin
            frames++;
            lastErr = rxFrameErr;
        end
    end
    task automatic cmp(input string what, input logic [31:0] want, input logic [31:0] got);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, want, got);
        end
    endtask : cmp
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // preamble, delimiter, then each byte low nibble first
    function automatic void mk_nibs(input int pre, input logic [7:0] b[$],
                                    output logic [3:0] q[$]);
        q = {};
        repeat (pre) q.push_back(NIB_PREAMBLE);
        q.push_back(NIB_SFD);
        foreach (b[i]) begin
            q.push_back(b[i][3:0]);
            q.push_back(b[i][7:4]);
        end
    endfunction : mk_nibs
    // wait a bounded time for a crossed event, then compare its count
    task automatic ev_check(input string what, input int k, input int old, input int add);
        int n;
        n = 0;
        while (evCnt[k] == old && n < 30) begin
            @(posedge core_clk);
            n++;
        end
        cmp(what, old + add, evCnt[k]);
    endtask : ev_check
    // offer one frame, optionally under collision, then judge the wire
    task automatic tx_frame(input int nb, input logic col);
        logic [7:0] b[$];
        logic [3:0] want[$];
        int n, c0, d0;
        c0 = evCnt[1];
        d0 = evCnt[0];
        for (int i = 0; i < nb; i++) b.push_back(8'($random(seed)));
        mk_nibs(15, b, want);
        u_mni_phy_model.txCap.delete();
        u_mni_phy_model.colOn = col;
        @(posedge txClk);
        foreach (b[i]) begin
            txData <= b[i];
            txValid <= 1'h1;
            txLast <= (i == nb - 1);
            n = 0;
            do begin
                @(posedge txClk);
                n++;
            end while (txReady !== 1'h1 && n < 300);
        end
        txValid <= 1'h0;
        n = 0;
        while (miiTxEn !== 1'h0 && n < 30) begin
            @(posedge txClk);
            n++;
        end
        u_mni_phy_model.colOn = 1'h0;
        if (col && !fullDuplex) begin
            cmp("cut frame", 1, u_mni_phy_model.txCap.size() < 16);
            foreach (u_mni_phy_model.txCap[i]) cmp("jam", NIB_JAM, u_mni_phy_model.txCap[i]);
            ev_check("collision event", 1, c0, 1);
        end else begin
            cmp("nibble count", want.size(), u_mni_phy_model.txCap.size());
            foreach (want[i]) cmp("tx nibble", want[i], u_mni_phy_model.txCap[i]);
            ev_check("done event", 0, d0, 1);
            cmp("no collision event", c0, evCnt[1]);
        end
    endtask : tx_frame
    // one frame with a preamble of 1 to 15 nibbles, optionally with an error nibble
    task automatic rx_frame(input int nb, input logic bad);
        logic [7:0] b[$];
        logic [3:0] q[$];
        int pre, f0, e0, n;
        pre = 1 + $unsigned($random(seed)) % 15;
        for (int i = 0; i < nb; i++) b.push_back(8'($random(seed)));
        mk_nibs(pre, b, q);
        rxGot.delete();
        f0 = frames;
        e0 = evCnt[3];
        u_mni_phy_model.send_nibs(q, bad ? pre + 2 : -1);
        n = 0;
        while (frames == f0 && n < 10) begin
            @(posedge rxClk);
            n++;
        end
        cmp("rx byte count", nb, rxGot.size());
        foreach (b[i]) cmp("rx byte", b[i], rxGot[i]);
        cmp("frame error", bad, lastErr);
        ev_check("rx error event", 3, e0, bad);
    endtask : rx_frame
    // main sequence
    initial begin
        int e4, e5;
        seed = 96343;
        {nrst, fullDuplex, txValid, txLast} = 4'h0;
        txData = 8'h00;
        repeat (4) @(posedge core_clk);
        nrst <= 1'h1;
        fullDuplex <= 1'h1;
        repeat (3) @(posedge txClk);
        // collision forced on odd frames must be ignored
        for (int f = 0; f < 3; f++) tx_frame(1 + $unsigned($random(seed)) % 6, f[0]);
        $display("test full duplex transmit done");
        @(posedge core_clk);
        fullDuplex <= 1'h0;
        repeat (3) @(posedge txClk);
        tx_frame(4, 1'h1);
        tx_frame(1, 1'h0);
        // underrun: the byte after the first never comes, so the frame is cut
        e4 = evCnt[2];
        u_mni_phy_model.txCap.delete();
        @(posedge txClk);
        txData <= 8'($random(seed));
        txValid <= 1'h1;
        txLast <= 1'h0;
        repeat (60) @(posedge txClk) if (txReady === 1'h1) txValid <= 1'h0;
        cmp("underrun nibbles", 18, u_mni_phy_model.txCap.size());
        ev_check("underrun event", 2, e4, 1);
        // a last byte ends the drain, then the gap follows
        @(posedge txClk);
        txLast <= 1'h1;
        txValid <= 1'h1;
        @(posedge txClk);
        txValid <= 1'h0;
        @(posedge txClk);
        cmp("drain left", 0, txReady);
        $display("test half duplex transmit done");
        for (int f = 0; f < 4; f++) rx_frame(1 + $unsigned($random(seed)) % 8, f == 2);
        $display("test receive done");
        codes[2] = 4'(1 + $unsigned($random(seed)) % 13);
        foreach (codes[i]) begin
            e4 = evCnt[4];
            e5 = evCnt[5];
            u_mni_phy_model.send_code(codes[i]);
            ev_check("false carrier", 4, e4, codes[i] == RX_CODE_FALSE_CARRIER);
            cmp("reserved code", e5 + (codes[i] != 4'hE && codes[i] != 4'h0), evCnt[5]);
        end
        $display("test idle codes done");
        complete_run();
    end
    // the whole run needs about a tenth of this span
    initial begin
        #1_000_000;
        err_total++;
        complete_run();
    end
endmodule : mni_media_if_tb
